// ==== rwg_pkg.sv ====
/*
 * Shared constants and carriers for the runtime watchdog, GPIO control and
 * monitor window register slice.
 * Assumes an 8-bit register port and a 200 MHz system clock.
 */
package rwg_pkg;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_WD_CTRL   = 8'h68;
	localparam logic [7:0] OFS_GPIO_DATA = 8'h69;
	localparam logic [7:0] OFS_TEST      = 8'h6D;
	localparam logic [7:0] OFS_GPIO_A    = 8'h6E;
	localparam logic [7:0] OFS_GPIO_B    = 8'h6F;
	localparam logic [7:0] OFS_MON_INDEX = 8'h70;
	localparam logic [7:0] OFS_MON_DATA  = 8'h71;
	localparam logic [7:0] OFS_GPIO_C    = 8'h72;
	localparam logic [7:0] OFS_GPIO_D    = 8'h73;
	localparam logic [7:0] OFS_RSVD_LO   = 8'h74;
	localparam logic [7:0] OFS_RSVD_HI   = 8'h7F;

	// Watchdog control fields
	localparam int WDC_STATUS = 0;
	localparam int WDC_FORCE  = 2;
	localparam int WDC_KBC_EN = 3;

	// GPIO control fields
	localparam int GPC_DIR    = 0;
	localparam int GPC_POL    = 1;
	localparam int GPC_ALT    = 2;
	localparam int GPC_ODRAIN = 7;
	localparam logic [7:0] GPC_MASK = 8'h87;

	// Unit select bit of the timeout configuration
	localparam int UNIT_SEL_SECONDS = 7;

	// Reset values
	localparam logic [7:0] WDC_RESET  = 8'h00;
	localparam logic [7:0] TEST_RESET = 8'h00;
	localparam logic [7:0] GPC_RESET  = 8'h01;
	localparam logic [7:0] MON_RESET  = 8'h00;
	localparam logic [3:0] GDAT_RESET = 4'h0;

	// Timing
	localparam longint CLK_HZ             = 200_000_000;
	localparam longint SECOND_S           = 1;
	localparam int     SECOND_CYCLES      = int'(SECOND_S * CLK_HZ);
	localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3C;

	localparam int NUM_GPIO = 4;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rwg_bus_req_t;

	typedef struct packed {
		logic                    wdc_status;
		logic                    wdc_kbc_en;
		logic                    kbc_prev;
		logic                    kbc_en_prev;
		logic [7:0]              test;
		logic [NUM_GPIO-1:0][7:0] gpc;
		logic [NUM_GPIO-1:0]     gpio_data;
		logic [7:0]              mon_index;
		logic [7:0]              mon_data;
		logic                    mon_wr;
		logic                    mon_rd;
		logic [31:0]             prescale;
		logic [5:0]              sec_cnt;
		logic [7:0]              unit_cnt;
		logic                    timeout;
		logic [7:0]              rdata;
		logic [NUM_GPIO-1:0]     pin_out;
		logic [NUM_GPIO-1:0]     pin_oe;
		logic [NUM_GPIO-1:0]     alt_rx;
	} rwg_state_t;

endpackage

// ==== rwg_regs.sv ====
/*
 * Runtime register slice: watchdog control with forced timeouts, test
 * register, four GPIO control registers with serial-6 alternate functions,
 * and an index/data window onto the hardware monitor block.
 * Assumes synchronous inputs, a monitor block whose read data follow
 * mon_addr_out combinationally, power-on reset on rst_b_in, and the VBAT reset on vbat_por_in.
 */
// Functional notes
// - Control bit 0 reads 1 after a watchdog timeout, 0 while counting.
// - Control clears on power-on; PCI reset clears all but status bit.
// - Writing 1 to write-only bit 2 forces a timeout; it self-clears.
// - With bit 3 set, a rising keyboard line edge forces a timeout.
// - Setting bit 3 while the keyboard line is high forces a timeout.
// - Keyboard line becomes one self-clearing pulse ORed with software force.
// - With bit 3 clear, the keyboard line never forces a timeout.
// - GPIO bit 0 sets direction: 1 input, 0 output.
// - GPIO bit 1 inverts the pin value in the data path.
// - GPIO bit 2 picks serial-6 alternate function, else plain GPIO.
// - GPIO bit 7 selects open-drain, else push-pull; bits 6-3 reserved.
// - GPIO control registers reset to 0x01, a plain input.
// - Monitor index register holds the monitor address being accessed.
// - Monitor data register reads and writes the indexed monitor register.
// - Monitor index and data registers reset to zero.
// - Offsets 74 to 7F are read-only and read zero.
// - Timeout count zero disables the watchdog; 1-255 give that many units.
// - Unit select bit 7 clear means minutes, set means seconds.
`timescale 1ns/10ps

module rwg_regs #(
	parameter int TICKS_PER_SECOND = rwg_pkg::SECOND_CYCLES
) (
	input  wire logic                         clk_in,
	input  wire logic                         rst_b_in,
	input  wire logic                         pci_rst_in,
	input  wire logic                         vbat_por_in,
	input  wire rwg_pkg::rwg_bus_req_t        bus_in,
	output logic [7:0]                        rdata_out,
	input  wire logic                         kbc_force_line_in,
	input  wire logic [7:0]                   watchdog_count_value_in,
	input  wire logic [7:0]                   watchdog_unit_config_in,
	output logic                              watchdog_timeout_out,
	input  wire logic [rwg_pkg::NUM_GPIO-1:0] gpio_pin_in,
	output logic [rwg_pkg::NUM_GPIO-1:0]      gpio_pin_out,
	output logic [rwg_pkg::NUM_GPIO-1:0]      gpio_pin_oe_out,
	input  wire logic                         serial6_transmit_in,
	output logic                              serial6_receive_out,
	output logic                              serial6_aux_in_out,
	input  wire logic                         serial6_aux_out_in,
	output logic [7:0]                        mon_addr_out,
	output logic [7:0]                        mon_wdata_out,
	output logic                              mon_wr_out,
	output logic                              mon_rd_out,
	input  wire logic [7:0]                   mon_rdata_in
);
	import rwg_pkg::*;

	rwg_state_t s;
	rwg_state_t next_s;

	logic                force_ev;
	logic                kbc_ev;
	logic                expire_ev;
	logic                any_ev;
	logic                wr_ctrl;
	logic [NUM_GPIO-1:0] dir_vec;
	logic [NUM_GPIO-1:0] od_vec;
	logic [NUM_GPIO-1:0] alt_tx;
	logic [NUM_GPIO-1:0] drive_val;

	// Maps an offset onto a GPIO control slot: {hit, index}
	function automatic logic [2:0] gpio_slot(input logic [7:0] a);
		logic [2:0] r;
		r = 3'h0;
		case (a)
			OFS_GPIO_A: r = 3'h4;
			OFS_GPIO_B: r = 3'h5;
			OFS_GPIO_C: r = 3'h6;
			OFS_GPIO_D: r = 3'h7;
			default:    r = 3'h0;
		endcase
		return r;
	endfunction

	// Alternate transmit sources: pins a and d drive, b and c receive
	assign alt_tx = {serial6_aux_out_in, 1'b0, 1'b0, serial6_transmit_in};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_GPIO; gi++) begin : g_pin
			assign dir_vec[gi] = s.gpc[gi][GPC_DIR];
			assign od_vec[gi]  = s.gpc[gi][GPC_ODRAIN];
			assign drive_val[gi] = (s.gpc[gi][GPC_ALT] ? alt_tx[gi]
				: s.gpio_data[gi]) ^ s.gpc[gi][GPC_POL];
		end
	endgenerate

	assign wr_ctrl = bus_in.wr && (bus_in.addr == OFS_WD_CTRL);

	// Software force, self-clearing since it is never stored
	assign force_ev = wr_ctrl && bus_in.wdata[WDC_FORCE];

	// One pulse per rising edge, or when enabled with line already high
	assign kbc_ev = s.wdc_kbc_en && kbc_force_line_in
		&& !(s.kbc_prev && s.kbc_en_prev);

	always_comb begin
		logic       sec_tick;
		logic       unit_tick;
		logic       running;
		logic [2:0] slot;
		logic [7:0] rmux;
		next_s    = s;
		sec_tick  = 1'b0;
		unit_tick = 1'b0;
		running   = 1'b0;
		slot      = gpio_slot(bus_in.addr);
		rmux      = 8'h00;
		expire_ev = 1'b0;
		any_ev    = 1'b0;

		// Watchdog counter; zero count disables it
		running = (watchdog_count_value_in != 8'h00) && !s.wdc_status;
		if (!running) begin
			next_s.prescale = 32'h0;
			next_s.sec_cnt  = 6'h0;
			next_s.unit_cnt = 8'h00;
		end else begin
			if (s.prescale == 32'(TICKS_PER_SECOND - 1)) begin
				next_s.prescale = 32'h0;
				sec_tick        = 1'b1;
			end else begin
				next_s.prescale = s.prescale + 32'h1;
			end
			if (sec_tick) begin
				if (watchdog_unit_config_in[UNIT_SEL_SECONDS]) begin
					unit_tick = 1'b1;
				end else if (s.sec_cnt == SECONDS_PER_MINUTE - 6'h1) begin
					next_s.sec_cnt = 6'h0;
					unit_tick      = 1'b1;
				end else begin
					next_s.sec_cnt = s.sec_cnt + 6'h1;
				end
			end
			if (unit_tick) begin
				if (s.unit_cnt + 8'h01 == watchdog_count_value_in) begin
					expire_ev = 1'b1;
				end else begin
					next_s.unit_cnt = s.unit_cnt + 8'h01;
				end
			end
		end

		any_ev = expire_ev || force_ev || kbc_ev;

		// Edge detector history
		next_s.kbc_prev    = kbc_force_line_in;
		next_s.kbc_en_prev = s.wdc_kbc_en;

		// Register writes; reserved control bits are not stored
		if (bus_in.wr) begin
			if (bus_in.addr == OFS_WD_CTRL) begin
				next_s.wdc_status = bus_in.wdata[WDC_STATUS];
				next_s.wdc_kbc_en = bus_in.wdata[WDC_KBC_EN];
			end
			if (bus_in.addr == OFS_TEST) begin
				next_s.test = bus_in.wdata;
			end
			if (slot[2]) begin
				next_s.gpc[slot[1:0]] = bus_in.wdata & GPC_MASK;
			end
			if (bus_in.addr == OFS_GPIO_DATA) begin
				next_s.gpio_data = bus_in.wdata[NUM_GPIO-1:0];
			end
			if (bus_in.addr == OFS_MON_INDEX) begin
				next_s.mon_index = bus_in.wdata;
			end
			if (bus_in.addr == OFS_MON_DATA) begin
				next_s.mon_data = bus_in.wdata;
			end
		end
		next_s.mon_wr = bus_in.wr && (bus_in.addr == OFS_MON_DATA);
		next_s.mon_rd = bus_in.rd && (bus_in.addr == OFS_MON_DATA);

		// PCI reset keeps the status bit only
		if (pci_rst_in) begin
			next_s.wdc_kbc_en = 1'b0;
			next_s.wdc_status = s.wdc_status;
		end
		if (vbat_por_in) begin
			next_s.test = TEST_RESET;
		end

		// A timeout event wins over any clear
		if (any_ev) begin
			next_s.wdc_status = 1'b1;
		end
		next_s.timeout = any_ev;

		// Read mux; unmapped and reserved offsets read zero
		if (slot[2]) begin
			rmux = s.gpc[slot[1:0]];
		end else begin
			case (bus_in.addr)
				OFS_WD_CTRL: begin
					rmux[WDC_STATUS] = s.wdc_status;
					rmux[WDC_KBC_EN] = s.wdc_kbc_en;
				end
				OFS_GPIO_DATA: rmux[NUM_GPIO-1:0] =
					gpio_pin_in ^ {s.gpc[3][GPC_POL], s.gpc[2][GPC_POL],
					s.gpc[1][GPC_POL], s.gpc[0][GPC_POL]};
				OFS_TEST:      rmux = s.test;
				OFS_MON_INDEX: rmux = s.mon_index;
				OFS_MON_DATA:  rmux = mon_rdata_in;
				default:       rmux = 8'h00;
			endcase
		end
		next_s.rdata = bus_in.rd ? rmux : 8'h00;

		// Pin drive: output only when direction is output
		next_s.pin_oe  = ~dir_vec & (~od_vec | ~drive_val);
		next_s.pin_out = drive_val & ~od_vec;
		next_s.alt_rx  = gpio_pin_in ^ {s.gpc[3][GPC_POL], s.gpc[2][GPC_POL],
			s.gpc[1][GPC_POL], s.gpc[0][GPC_POL]};
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s             <= '0;
			s.wdc_status  <= WDC_RESET[WDC_STATUS];
			s.wdc_kbc_en  <= WDC_RESET[WDC_KBC_EN];
			s.test        <= TEST_RESET;
			s.gpc         <= {NUM_GPIO{GPC_RESET}};
			s.gpio_data   <= GDAT_RESET;
			s.mon_index   <= MON_RESET;
			s.mon_data    <= MON_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign rdata_out            = s.rdata;
	assign watchdog_timeout_out = s.timeout;
	assign gpio_pin_out         = s.pin_out;
	assign gpio_pin_oe_out      = s.pin_oe;
	assign serial6_receive_out  = s.alt_rx[1];
	assign serial6_aux_in_out   = s.alt_rx[2];
	assign mon_addr_out         = s.mon_index;
	assign mon_wdata_out        = s.mon_data;
	assign mon_wr_out           = s.mon_wr;
	assign mon_rd_out           = s.mon_rd;

	// Checks
	status_on_event_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(force_ev || kbc_ev || expire_ev) |=> s.wdc_status
			&& watchdog_timeout_out)
		else $error("timeout event did not set status");

	pci_keeps_status_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(pci_rst_in && !any_ev) |=> (s.wdc_status == $past(s.wdc_status))
			&& !s.wdc_kbc_en)
		else $error("pci reset altered status or kept enable");

	force_bit_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(wr_ctrl && bus_in.wdata[WDC_FORCE])
			##1 (bus_in.rd && bus_in.addr == OFS_WD_CTRL)
			|=> !rdata_out[WDC_FORCE] && rdata_out[WDC_STATUS])
		else $error("force bit stuck or status not set");

	kbc_edge_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(s.wdc_kbc_en && s.kbc_en_prev && $rose(kbc_force_line_in))
			|-> kbc_ev)
		else $error("keyboard line edge missed");

	kbc_high_arm_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(wr_ctrl && bus_in.wdata[WDC_KBC_EN] && !s.wdc_kbc_en && !pci_rst_in)
			##1 kbc_force_line_in |-> kbc_ev)
		else $error("enable with high line gave no event");

	kbc_one_shot_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		kbc_ev ##1 (kbc_force_line_in && s.wdc_kbc_en) [*3] |-> !kbc_ev)
		else $error("held keyboard line gave repeated events");

	kbc_gated_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		kbc_ev |-> s.wdc_kbc_en && kbc_force_line_in)
		else $error("keyboard event while disabled");

	input_no_drive_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		1'b1 |=> (gpio_pin_oe_out & $past(dir_vec)) == 4'h0)
		else $error("input pin is driven");

	receive_path_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		1'b1 |=> serial6_receive_out ==
			($past(gpio_pin_in[1]) ^ $past(s.gpc[1][GPC_POL])))
		else $error("receive polarity wrong");

	open_drain_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		1'b1 |=> (gpio_pin_out & $past(od_vec)) == 4'h0)
		else $error("open drain pin drives high");

	mon_window_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(bus_in.rd && bus_in.addr == OFS_MON_DATA)
			|=> rdata_out == $past(mon_rdata_in) && mon_rd_out)
		else $error("monitor data read mismatch");

	reserved_zero_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(bus_in.rd && bus_in.addr >= OFS_RSVD_LO
			&& bus_in.addr <= OFS_RSVD_HI) |=> rdata_out == 8'h00)
		else $error("reserved offset read nonzero");

	count_zero_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(watchdog_count_value_in == 8'h00) |-> !expire_ev)
		else $error("disabled watchdog expired");

	gpio_rsvd_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(bus_in.rd && gpio_slot(bus_in.addr) != 3'h0)
			|=> (rdata_out & ~GPC_MASK) == 8'h00)
		else $error("reserved gpio bits read nonzero");

	status_write_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(wr_ctrl && !any_ev && !pci_rst_in)
			|=> s.wdc_status == $past(bus_in.wdata[WDC_STATUS]))
		else $error("status bit did not take written value");

	ctrl_read_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(bus_in.rd && bus_in.addr == OFS_WD_CTRL) |=> rdata_out
			== {4'h0, $past(s.wdc_kbc_en), 2'h0, $past(s.wdc_status)})
		else $error("control register read wrong");

	kbc_disabled_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(!s.wdc_kbc_en && !force_ev && !expire_ev)
			|=> !watchdog_timeout_out)
		else $error("timeout while keyboard line disabled");

	timeout_status_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		watchdog_timeout_out |-> s.wdc_status)
		else $error("timeout pulse without status");

	push_pull_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		1'b1 |=> (gpio_pin_oe_out | $past(dir_vec) | $past(od_vec)) == 4'hF)
		else $error("push-pull output pin not driven");

	index_addr_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(bus_in.wr && bus_in.addr == OFS_MON_INDEX)
			|=> mon_addr_out == $past(bus_in.wdata))
		else $error("monitor index not presented");

	mon_write_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(bus_in.wr && bus_in.addr == OFS_MON_DATA)
			|=> mon_wr_out && mon_wdata_out == $past(bus_in.wdata))
		else $error("monitor data write not presented");

endmodule

// ==== tb_runtime_wdt_gpio_hwm_regs.sv ====
/*
 * Self-checking bench for the runtime watchdog, GPIO and monitor slice.
 * Assumes rwg_pkg and rwg_regs; the monitor block is a combinational
 * stand-in that returns the index xor 0xA5.
 */
`timescale 1ns/10ps

module tb_runtime_wdt_gpio_hwm_regs;
	import rwg_pkg::*;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} rwg_row_t;

	logic         clk_in = 1'b0;
	logic         rst_b_in = 1'b0;
	logic         pci_rst_in = 1'b0;
	logic         vbat_por_in = 1'b0;
	rwg_bus_req_t bus_in = '0;
	logic [7:0]   rdata_out;
	logic         kbc_force_line_in = 1'b0;
	logic [7:0]   cnt_val = 8'h00;
	logic [7:0]   unit_cfg = 8'h00;
	logic         watchdog_timeout_out;
	logic [3:0]   gpio_pin_in = 4'h0;
	logic [3:0]   gpio_pin_out;
	logic [3:0]   gpio_pin_oe_out;
	logic         tx_src = 1'b0;
	logic         serial6_receive_out;
	logic         serial6_aux_in_out;
	logic         aux_src = 1'b0;
	logic [7:0]   mon_addr_out;
	logic [7:0]   mon_wdata_out;
	logic         mon_wr_out;
	logic         mon_rd_out;
	logic [7:0]   mon_rdata_in;
	int           n_mismatch = 0;
	int           checked = 0;
	int           n_tmo = 0;
	int           n_mwr = 0;
	int           n_mrd = 0;
	int           base;
	int           k;
	// Test register is left unwritten
	rwg_row_t     rows [11] = '{
		'{8'h6E, 8'hFF, 8'h87}, '{8'h6F, 8'h86, 8'h86}, '{8'h72, 8'h02, 8'h02},
		'{8'h73, 8'h81, 8'h81}, '{8'h70, 8'hC3, 8'hC3}, '{8'h70, 8'h5A, 8'h5A},
		'{8'h71, 8'h33, 8'hFF}, '{8'h74, 8'hFF, 8'h00}, '{8'h7F, 8'hFF, 8'h00},
		'{8'h6A, 8'hFF, 8'h00}, '{8'h68, 8'h08, 8'h08}};

	always #2.5 clk_in = ~clk_in;

	// Monitor register block stand-in
	assign mon_rdata_in = mon_addr_out ^ 8'hA5;

	always @(posedge clk_in) begin
		if (watchdog_timeout_out === 1'b1) n_tmo++;
		if (mon_wr_out === 1'b1) n_mwr++;
		if (mon_rd_out === 1'b1) n_mrd++;
	end

	rwg_regs #(
		.TICKS_PER_SECOND(10)
	) rwg_regs_i (
		.clk_in                 (clk_in),
		.rst_b_in               (rst_b_in),
		.pci_rst_in             (pci_rst_in),
		.vbat_por_in            (vbat_por_in),
		.bus_in                 (bus_in),
		.rdata_out              (rdata_out),
		.kbc_force_line_in      (kbc_force_line_in),
		.watchdog_count_value_in(cnt_val),
		.watchdog_unit_config_in(unit_cfg),
		.watchdog_timeout_out   (watchdog_timeout_out),
		.gpio_pin_in            (gpio_pin_in),
		.gpio_pin_out           (gpio_pin_out),
		.gpio_pin_oe_out        (gpio_pin_oe_out),
		.serial6_transmit_in    (tx_src),
		.serial6_receive_out    (serial6_receive_out),
		.serial6_aux_in_out     (serial6_aux_in_out),
		.serial6_aux_out_in     (aux_src),
		.mon_addr_out           (mon_addr_out),
		.mon_wdata_out          (mon_wdata_out),
		.mon_wr_out             (mon_wr_out),
		.mon_rd_out             (mon_rd_out),
		.mon_rdata_in           (mon_rdata_in)
	);

	task automatic final_report();
		if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] seen,
			input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic bus_op(input logic [7:0] a, input logic [7:0] w,
			input logic r);
		@(posedge clk_in);
		bus_in <= '{addr: a, wdata: w, wr: !r, rd: r};
		@(posedge clk_in);
		bus_in.wr <= 1'b0;
		bus_in.rd <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		bus_op(a, w, 1'b0);
	endtask

	task automatic rd(input string nm, input logic [7:0] a,
			input logic [7:0] e);
		bus_op(a, 8'h00, 1'b1);
		chk(nm, rdata_out, e);
	endtask

	// Write then read with no idle cycle between the strobes
	task automatic wr_rd(input string nm, input logic [7:0] a,
			input logic [7:0] w, input logic [7:0] e);
		@(posedge clk_in);
		bus_in <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		bus_in.rd <= 1'b0;
		#1;
		chk(nm, rdata_out, e);
	endtask

	task automatic kbc(input logic v);
		@(posedge clk_in);
		kbc_force_line_in <= v;
	endtask

	// Cycles from now until the next timeout pulse, bounded
	task automatic expiry(output int n);
		base = n_tmo;
		n = 0;
		while (n_tmo == base && n < 1000) begin
			tick(1);
			n++;
		end
	endtask

	initial begin
		#50000;
		n_mismatch++;
		final_report();
	end

	initial begin
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1'b1;
		foreach (rows[i]) rd("gpio_rst", OFS_GPIO_A + 8'(i % 2), 8'h01);
		rd("gpio_c_rst", OFS_GPIO_C, 8'h01);
		rd("gpio_d_rst", OFS_GPIO_D, 8'h01);
		rd("wdc_rst", OFS_WD_CTRL, 8'h00);
		rd("test_rst", OFS_TEST, 8'h00);
		rd("index_rst", OFS_MON_INDEX, 8'h00);
		chk("wdata_rst", mon_wdata_out, 8'h00);
		chk("oe_rst", 8'(gpio_pin_oe_out), 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd("row", rows[i].a, rows[i].e);
		end
		@(posedge clk_in);
		vbat_por_in <= 1'b1;
		@(posedge clk_in);
		vbat_por_in <= 1'b0;
		rd("test_vbat", OFS_TEST, 8'h00);
		// Software force and self-clearing
		wr(OFS_WD_CTRL, 8'h00);
		base = n_tmo;
		wr(OFS_WD_CTRL, 8'h04);
		tick(4);
		chk("force_pulse", 8'(n_tmo - base), 8'h01);
		rd("force_stat", OFS_WD_CTRL, 8'h01);
		wr(OFS_WD_CTRL, 8'h00);
		rd("stat_clr", OFS_WD_CTRL, 8'h00);
		// Keyboard line ignored while disabled
		kbc(1'b1);
		tick(10);
		chk("kbc_off", 8'(n_tmo - base), 8'h01);
		kbc(1'b0);
		wr(OFS_WD_CTRL, 8'h08);
		tick(3);
		kbc(1'b1);
		tick(20);
		chk("kbc_edge", 8'(n_tmo - base), 8'h02);
		rd("kbc_stat", OFS_WD_CTRL, 8'h09);
		@(posedge clk_in);
		pci_rst_in <= 1'b1;
		@(posedge clk_in);
		pci_rst_in <= 1'b0;
		rd("pci_rst", OFS_WD_CTRL, 8'h01);
		wr(OFS_WD_CTRL, 8'h00);
		wr(OFS_WD_CTRL, 8'h08);
		tick(4);
		chk("kbc_high", 8'(n_tmo - base), 8'h03);
		wr(OFS_WD_CTRL, 8'h0C);
		tick(4);
		chk("force_en", 8'(n_tmo - base), 8'h04);
		kbc(1'b0);
		// Counter expiry in seconds, then minutes, then disabled
		@(posedge clk_in);
		cnt_val <= 8'h01;
		unit_cfg <= 8'h80;
		wr(OFS_WD_CTRL, 8'h00);
		expiry(k);
		chk("sec_expiry", 8'(k >= 8 && k <= 13), 8'h01);
		rd("exp_stat", OFS_WD_CTRL, 8'h01);
		@(posedge clk_in);
		unit_cfg <= 8'h00;
		wr(OFS_WD_CTRL, 8'h00);
		expiry(k);
		chk("min_expiry", 8'(k >= 598 && k <= 606), 8'h01);
		@(posedge clk_in);
		cnt_val <= 8'h00;
		wr(OFS_WD_CTRL, 8'h00);
		expiry(k);
		chk("disabled", 8'(k), 8'(1000));
		// GPIO pin paths
		wr(OFS_GPIO_A, 8'h78);
		wr(OFS_GPIO_DATA, 8'h01);
		tick(3);
		chk("pp_out", {6'h00, gpio_pin_oe_out[0], gpio_pin_out[0]}, 8'h03);
		wr(OFS_GPIO_A, 8'h02);
		tick(3);
		chk("pol_out", {6'h00, gpio_pin_oe_out[0], gpio_pin_out[0]}, 8'h02);
		wr(OFS_GPIO_A, 8'h80);
		tick(3);
		chk("od_high", 8'(gpio_pin_oe_out[0]), 8'h00);
		wr(OFS_GPIO_DATA, 8'h00);
		tick(3);
		chk("od_low", {6'h00, gpio_pin_oe_out[0], gpio_pin_out[0]}, 8'h02);
		wr(OFS_GPIO_A, 8'h01);
		tick(3);
		chk("dir_in", 8'(gpio_pin_oe_out[0]), 8'h00);
		@(posedge clk_in);
		tx_src <= 1'b1;
		aux_src <= 1'b1;
		gpio_pin_in <= 4'h6;
		wr(OFS_GPIO_A, 8'h04);
		wr(OFS_GPIO_D, 8'h04);
		wr(OFS_GPIO_B, 8'h05);
		wr(OFS_GPIO_C, 8'h07);
		tick(3);
		chk("alt_tx", {6'h00, gpio_pin_out[0], gpio_pin_out[3]}, 8'h03);
		chk("alt_rx", {6'h00, serial6_receive_out, serial6_aux_in_out}, 8'h02);
		// Monitor window
		base = n_mwr;
		wr(OFS_MON_INDEX, 8'h12);
		wr(OFS_MON_DATA, 8'h5C);
		tick(2);
		chk("mon_addr", mon_addr_out, 8'h12);
		chk("mon_wdata", mon_wdata_out, 8'h5C);
		chk("mon_wr", 8'(n_mwr - base), 8'h01);
		base = n_mrd;
		rd("mon_rd", OFS_MON_DATA, 8'hB7);
		tick(2);
		chk("mon_rd_pulse", 8'(n_mrd - base), 8'h01);
		// Back-to-back force and read, then power-on reset in mid-run
		wr_rd("force_b2b", OFS_WD_CTRL, 8'h04, 8'h01);
		@(posedge clk_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		rd("wdc_por", OFS_WD_CTRL, 8'h00);
		rd("gpio_por", OFS_GPIO_A, 8'h01);
		rd("index_por", OFS_MON_INDEX, 8'h00);
		final_report();
	end
endmodule
